//--- include/cesp_defs.svh
// register map, bit positions and timing constants for the eeprom serial port
`ifndef CESP_DEFS_SVH
`define CESP_DEFS_SVH
`define CESP_OFS_CMD 2'h0
`define CESP_OFS_TXB 2'h1
`define CESP_OFS_RXB 2'h2
`define CESP_B_RST 0
`define CESP_B_START 1
`define CESP_B_STOP 2
`define CESP_B_WR 3
`define CESP_B_RDA 4
`define CESP_B_RDS 5
`define CESP_B_ACK 6
`define CESP_B_EN 7
`define CESP_B_MAN 8
`define CESP_B_SCLF 9
`define CESP_B_SDAF 10
`define CESP_B_SDI 11
`define CESP_CLK_HZ 40000000
`define CESP_SER_HZ 400000
`define CESP_QDIV (`CESP_CLK_HZ / (`CESP_SER_HZ * 4))
`define CESP_RST_CLOCKS 9
`define CESP_ACK_SLOT 8
`endif

//--- include/cesp_pkg.sv
// types shared by the eeprom serial port
`default_nettype none
package cesp_pkg;
  typedef struct packed {
    logic scl;
    logic sda_oe_b;
    logic cfg_en;
  } cesp_pins_t;
  typedef enum logic [5:0] {
    CESP_IDLE = 6'h01,
    CESP_RST = 6'h02,
    CESP_START = 6'h04,
    CESP_STOP = 6'h08,
    CESP_BIT = 6'h10,
    CESP_DONE = 6'h20
  } cesp_state_t;
endpackage
`default_nettype wire

//--- rtl/cesp_port.sv
// eeprom serial port: command/status, transmit and receive registers
// Behaviour
// - three registers: command, transmit, receive
// - read byte appears in receive register
// - reset by bus reset or command bit
// - system reset starts port reset sequence
// - serial side runs near 400 khz
// - reset bit reads busy during sequence
// - command bits start on one, read busy
// - start bit generates start condition
// - stop bit generates stop condition
// - write shifts byte out, samples ack
// - ack flag reports missing acknowledge
// - serial enable bit, read back, resets low
// - manual bit selects pin override mode
// - manual clock level bit
// - manual data level bit
// - data input level readable
// - upper bits read zero
// - reads end with ack or stop
`default_nettype none
`include "cesp_defs.svh"
module cesp_port
  import cesp_pkg::*;
#(
  parameter int QDIV = `CESP_QDIV
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  // serial pins
  output logic ser_clk,
  output logic ser_dat_oe_b,
  input wire logic ser_dat_in,
  output logic cfg_serial_en
);
  // pin input passes two flops before use
  logic sdi_m_q, sdi_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sdi_m_q <= 1'b1;
      sdi_q <= 1'b1;
    end else begin
      sdi_m_q <= ser_dat_in;
      sdi_q <= sdi_m_q;
    end
  end

  // quarter-bit enable; four per serial bit gives about 400 khz
  logic [15:0] div_q, div_d;
  logic tick;
  assign tick = (div_q == 16'(QDIV - 1));
  always_comb begin
    div_d = tick ? 16'h0000 : div_q + 16'h0001;
  end

  cesp_state_t st_q, st_d;
  logic [5:0] busy_q, busy_d;
  logic [1:0] ph_q, ph_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] tx_q, tx_d, rx_q, rx_d, sh_q, sh_d;
  logic ack_q, ack_d, en_q, en_d, man_q, man_d, sclf_q, sclf_d, sdaf_q, sdaf_d;
  logic scl_q, scl_d, sda_q, sda_d;
  logic [31:0] rd_d;
  cesp_pins_t pins_q, pins_d;
  logic wr_cmd;
  logic [5:0] go;
  // writes to the ack flag, input level and upper bits have no target
  assign wr_cmd = reg_wr && (reg_addr == `CESP_OFS_CMD);
  assign go = reg_wdata[5:0];

  always_comb begin
    st_d = st_q;
    busy_d = busy_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    rx_d = rx_q;
    sh_d = sh_q;
    ack_d = ack_q;
    en_d = en_q;
    man_d = man_q;
    sclf_d = sclf_q;
    sdaf_d = sdaf_q;
    scl_d = scl_q;
    sda_d = sda_q;
    if (reg_wr && reg_addr == `CESP_OFS_TXB) begin
      tx_d = reg_wdata[7:0];
    end
    if (wr_cmd) begin
      en_d = reg_wdata[`CESP_B_EN];
      man_d = reg_wdata[`CESP_B_MAN];
      sclf_d = reg_wdata[`CESP_B_SCLF];
      sdaf_d = reg_wdata[`CESP_B_SDAF];
    end
    // a new command other than reset is only taken when idle; others are dropped
    if (wr_cmd && go[`CESP_B_RST]) begin
      // reset preempts any operation in flight
      busy_d = 6'h01;
      st_d = CESP_RST;
      cnt_d = 4'h0;
      ph_d = 2'h0;
      sda_d = 1'b1;
    end else if (wr_cmd && st_q == CESP_IDLE && go != 6'h00) begin
      ph_d = 2'h0;
      cnt_d = 4'h0;
      if (go[`CESP_B_START]) begin
        busy_d = 6'h02;
        st_d = CESP_START;
      end else if (go[`CESP_B_STOP]) begin
        busy_d = 6'h04;
        st_d = CESP_STOP;
      end else if (go[`CESP_B_WR]) begin
        busy_d = 6'h08;
        sh_d = tx_q;
        st_d = CESP_BIT;
      end else if (go[`CESP_B_RDA]) begin
        busy_d = 6'h10;
        st_d = CESP_BIT;
      end else begin
        busy_d = 6'h20;
        st_d = CESP_BIT;
      end
    end else if (tick) begin
      ph_d = ph_q + 2'h1;
      case (st_q)
        CESP_RST: begin
          // clock out nine pulses with data released, then stop
          sda_d = 1'b1;
          scl_d = ph_q[1];
          if (ph_q == 2'h3) begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'(`CESP_RST_CLOCKS - 1)) begin
              st_d = CESP_STOP;
            end
          end
        end
        CESP_START: begin
          case (ph_q)
            2'h0: sda_d = 1'b1;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b0;
            default: begin
              scl_d = 1'b0;
              st_d = CESP_DONE;
            end
          endcase
        end
        CESP_STOP: begin
          case (ph_q)
            2'h0: sda_d = 1'b0;
            2'h1: scl_d = 1'b1;
            2'h2: sda_d = 1'b1;
            default: st_d = CESP_DONE;
          endcase
        end
        CESP_BIT: begin
          // bits 0..7 data, then the acknowledge slot
          // a write shifts the byte out msb first; a read shifts the line in
          case (ph_q)
            2'h0: begin
              scl_d = 1'b0;
              if (cnt_q == 4'(`CESP_ACK_SLOT)) begin
                // acknowledge a continued read, release the line otherwise
                sda_d = busy_q[`CESP_B_RDA] ? 1'b0 : 1'b1;
              end else begin
                sda_d = busy_q[`CESP_B_WR] ? sh_q[7] : 1'b1;
              end
            end
            2'h1: scl_d = 1'b1;
            2'h2: begin
              if (cnt_q == 4'(`CESP_ACK_SLOT)) begin
                // only a byte write updates the flag; reads leave it alone
                if (busy_q[`CESP_B_WR]) begin
                  ack_d = sdi_q;
                end
              end else begin
                sh_d = {sh_q[6:0], sdi_q};
              end
            end
            default: begin
              scl_d = 1'b0;
              cnt_d = cnt_q + 4'h1;
              if (cnt_q == 4'(`CESP_ACK_SLOT)) begin
                if (!busy_q[`CESP_B_WR]) begin
                  rx_d = sh_q;
                end
                st_d = busy_q[`CESP_B_RDS] ? CESP_STOP : CESP_DONE;
              end
            end
          endcase
        end
        CESP_DONE: begin
          busy_d = 6'h00;
          st_d = CESP_IDLE;
        end
        default: begin
          ph_d = 2'h0;
        end
      endcase
    end
  end

  // output and readback
  // manual mode only swaps the pins; the sequencer keeps running underneath
  always_comb begin
    pins_d.scl = man_q ? sclf_q : scl_q;
    pins_d.sda_oe_b = man_q ? sdaf_q : sda_q;
    pins_d.cfg_en = en_q;
    rd_d = 32'h0000_0000;
    case (reg_addr)
      `CESP_OFS_CMD: begin
        rd_d[5:0] = busy_q;
        rd_d[`CESP_B_ACK] = ack_q;
        rd_d[`CESP_B_EN] = en_q;
        rd_d[`CESP_B_MAN] = man_q;
        rd_d[`CESP_B_SCLF] = sclf_q;
        rd_d[`CESP_B_SDAF] = sdaf_q;
        rd_d[`CESP_B_SDI] = sdi_q;
      end
      `CESP_OFS_TXB: rd_d[7:0] = tx_q;
      `CESP_OFS_RXB: rd_d[7:0] = rx_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // divider runs free, so quarter ticks keep their spacing across commands
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_d;
    end
  end

  // reset enters the port reset sequence with its bit busy
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= CESP_RST;
      busy_q <= 6'h01;
      ph_q <= 2'h0;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b1;
    end else begin
      st_q <= st_d;
      busy_q <= busy_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      sh_q <= sh_d;
      ack_q <= ack_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // software-written configuration and transmit byte
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= 8'h00;
      en_q <= 1'b0;
      man_q <= 1'b0;
      sclf_q <= 1'b0;
      sdaf_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      en_q <= en_d;
      man_q <= man_d;
      sclf_q <= sclf_d;
      sdaf_q <= sdaf_d;
    end
  end

  // pins and read data cost a cycle of latency but leave glitch-free outputs
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pins_q <= '{scl: 1'b0, sda_oe_b: 1'b1, cfg_en: 1'b0};
      reg_rdata <= 32'h0000_0000;
    end else begin
      pins_q <= pins_d;
      reg_rdata <= rd_d;
    end
  end

  // open-drain data: enable low pulls line low, high releases it
  assign ser_clk = pins_q.scl;
  assign ser_dat_oe_b = pins_q.sda_oe_b;
  assign cfg_serial_en = pins_q.cfg_en;
endmodule
`default_nettype wire

//--- testbench/cesp_port_props.sv
// assertions on the eeprom serial port ports
`default_nettype none
module cesp_port_props #(
  parameter int QDIV = 2
) (
  // clock, reset, register port
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  // serial pins
  input wire logic ser_clk,
  input wire logic ser_dat_oe_b,
  input wire logic ser_dat_in,
  input wire logic cfg_serial_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // cycles the serial clock has stood high, saturating
  logic [15:0] hi_cnt_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cnt_q <= 16'h0000;
    end else if (!ser_clk) begin
      hi_cnt_q <= 16'h0000;
    end else if (hi_cnt_q != 16'hffff) begin
      hi_cnt_q <= hi_cnt_q + 16'h0001;
    end
  end
  // pins are registered behind the control bits, so they follow two cycles later
  property man_pins_p;
    logic c, d;
    (reg_wr && reg_addr == 2'h0 && reg_wdata[8], c = reg_wdata[9], d = reg_wdata[10])
      |-> ##2 (ser_clk == c && ser_dat_oe_b == d);
  endproperty
  rst_busy_a: assert property (
    (reg_wr && reg_addr == 2'h0 && reg_wdata[0]) ##1 reg_addr == 2'h0 |=> reg_rdata[0])
    else $error("reset bit not busy");
  high_zero_a: assert property (reg_rdata[31:12] == 20'h0)
    else $error("upper bits set");
  byte_regs_a: assert property (
    $past(reg_addr) != 2'h0 |-> reg_rdata[31:8] == 24'h0) else $error("byte reg too wide");
  en_write_a: assert property (
    reg_wr && reg_addr == 2'h0 |-> ##2 cfg_serial_en == $past(reg_wdata[7], 2))
    else $error("enable pin wrong");
  en_read_a: assert property (
    $past(reg_addr) == 2'h0 |-> reg_rdata[7] == cfg_serial_en)
    else $error("enable readback wrong");
  man_pins_a: assert property (man_pins_p)
    else $error("manual pins wrong");
  sdi_high_a: assert property (
    (ser_dat_in && reg_addr == 2'h0) [*5] |=> reg_rdata[11]) else $error("data level wrong");
  sdi_low_a: assert property (
    (!ser_dat_in && reg_addr == 2'h0) [*5] |=> !reg_rdata[11]) else $error("data level wrong");
  scl_high_a: assert property ($rose(ser_clk) |=> ser_clk [*3])
    else $error("clock high too short");
  scl_width_a: assert property ($fell(ser_clk) |-> hi_cnt_q >= 16'(2 * QDIV))
    else $error("clock high shorter than half a bit");
  cover property (reg_wr && reg_addr == 2'h0 && reg_wdata[3]);
  cover property (reg_wr && reg_addr == 2'h0 && reg_wdata[5]);
  cover property ($fell(ser_dat_oe_b) && ser_clk);
endmodule
bind cesp_port cesp_port_props #(.QDIV(QDIV)) u_props (.mclk(mclk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ser_clk(ser_clk), .ser_dat_oe_b(ser_dat_oe_b), .ser_dat_in(ser_dat_in),
  .cfg_serial_en(cfg_serial_en));
`default_nettype wire

//--- testbench/cesp_eeprom_model.sv
// behavioural serial eeprom on the two-wire link
`default_nettype none
module cesp_eeprom_model (
  // link pins, data line pulled up
  input wire logic ser_clk,
  input wire logic ser_dat_oe_b,
  output logic sda,
  // bench controls and observations
  input wire logic rd_mode,
  input wire logic ack_en,
  input wire logic [7:0] rd_byte,
  output logic [7:0] got,
  output logic ack_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h9;
  logic pull;
  assign pull = rd_mode ? (cnt < 4'h8 && !rd_byte[3'(4'h7 - cnt)])
                        : (cnt == 4'h8 && ack_en);
  assign sda = ser_dat_oe_b & !pull;
  // start condition re-arms the bit counter
  always @(negedge sda) if (ser_clk) cnt = 4'h8;
  always @(negedge ser_clk) if (cnt == 4'h8) cnt = 4'h0; else if (cnt < 4'h8) cnt = cnt + 4'h1;
  // a nack from the port ends our driving, so its stop is not blocked
  always @(posedge ser_clk) begin
    if (cnt < 4'h8) got = {got[6:0], sda};
    else if (cnt == 4'h8) begin
      ack_seen = sda;
      if (rd_mode && sda) cnt = 4'h9;
    end
  end
endmodule
`default_nettype wire

//--- testbench/cesp_port_tb.sv
// self-checking bench for the eeprom serial port
`default_nettype none
module cesp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic reg_wr = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, v;
  logic ser_clk, ser_dat_oe_b, ser_dat_in, cfg_serial_en, ack_seen;
  logic rd_mode = 1'b0;
  logic ack_en = 1'b0;
  logic [7:0] rd_byte = 8'h0;
  logic [7:0] got;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  always #12.5 mclk = ~mclk;
  cesp_port #(.QDIV(2)) u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ser_clk(ser_clk),
    .ser_dat_oe_b(ser_dat_oe_b), .ser_dat_in(ser_dat_in), .cfg_serial_en(cfg_serial_en));
  cesp_eeprom_model u_prom (.ser_clk(ser_clk), .ser_dat_oe_b(ser_dat_oe_b), .sda(ser_dat_in),
    .rd_mode(rd_mode), .ack_en(ack_en), .rd_byte(rd_byte), .got(got), .ack_seen(ack_seen));
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge mclk);
    #1 reg_wr = 1'b0;
  endtask
  // read data lags the address by a cycle; hold it longer to be safe
  task automatic rd(input logic [1:0] a, output logic [31:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    repeat (3) @(posedge mclk);
    #1 d = reg_rdata;
  endtask
  task automatic wait_idle;
    int i = 0;
    rd(2'h0, v);
    while (v[5:0] !== 6'h0 && i < 300) begin
      rd(2'h0, v);
      i++;
    end
    chk(32'(v[5:0]), 32'h0);
  endtask
  task automatic cmd(input logic [31:0] c);
    wr(2'h0, c);
    rd(2'h0, v);
    chk(v & c & 32'h3f, c & 32'h3f);
    wait_idle();
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
    rd(2'h0, v);
    chk(v & 32'h1, 32'h1);
    wait_idle();
    rd(2'h0, v);
    chk(v & 32'hffffffbf, 32'h800);
    cmd(32'h2);
    ack_en = 1'b1;
    wr(2'h1, 32'ha5);
    cmd(32'h8);
    rd(2'h0, v);
    chk(v & 32'h40, 32'h0);
    chk(32'(got), 32'ha5);
    ack_en = 1'b0;
    wr(2'h1, 32'h3c);
    cmd(32'h8);
    rd(2'h0, v);
    chk(v & 32'h40, 32'h40);
    chk(32'(got), 32'h3c);
    rd(2'h1, v);
    chk(v, 32'h3c);
    rd(2'h3, v);
    chk(v, 32'h0);
    {rd_mode, rd_byte} = {1'b1, 8'h96};
    cmd(32'h10);
    rd(2'h2, v);
    chk(v, 32'h96);
    chk(32'(ack_seen), 32'h0);
    rd_byte = 8'h5a;
    cmd(32'h20);
    rd(2'h2, v);
    chk(v, 32'h5a);
    chk(32'(ack_seen), 32'h1);
    rd_mode = 1'b0;
    cmd(32'h4);
    chk(32'({ser_clk, ser_dat_oe_b}), 32'h3);
    wr(2'h0, 32'hfffff7c0);
    rd(2'h0, v);
    chk(v & 32'hffffffbf, 32'hf80);
    wr(2'h0, 32'h180);
    repeat (4) @(posedge mclk);
    rd(2'h0, v);
    chk(v & 32'hffffffbf, 32'h180);
    chk(32'({ser_clk, ser_dat_oe_b, cfg_serial_en}), 32'h1);
    wr(2'h0, 32'h0);
    // let the clock handed back to the sequencer stand high a full half bit
    repeat (4) @(posedge mclk);
    cmd(32'h1);
    test_done();
  end
endmodule
`default_nettype wire
